// [verilog/clk_gate_pkg.sv]
// Register map, field layout and reset values of the clock gating block
`default_nettype none
package clk_gate_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_IRQ = 8'h08;
	localparam logic [7:0] OFF_HIGH_RST = 8'h0c;
	localparam logic [7:0] OFF_LOW_RST = 8'h10;
	localparam logic [7:0] OFF_SYS_EN = 8'h14;
	localparam logic [7:0] OFF_HIGH_EN = 8'h18;
	localparam logic [7:0] OFF_SUPERVISE = 8'h20;
	// Event sources: slow, fast, ext, pll, fail
	localparam int NUM_SRC = 5;
	localparam int SRC_FAIL = 4;
	localparam int FLAG_SLOW_POS = 0;
	localparam int FLAG_FAST_POS = 2;
	localparam int FLAG_EXT_POS = 3;
	localparam int FLAG_PLL_POS = 4;
	localparam int FLAG_FAIL_POS = 7;
	// Enable sits 8 above its flag, clear 16 above
	localparam int ENABLE_SHIFT = 8;
	localparam int CLEAR_SHIFT = 16;
	// Writable fields of each register
	localparam logic [31:0] IRQ_ENABLE_MASK = 32'h0000_1d00;
	localparam logic [14:0] HIGH_MASK = 15'h5a35;
	localparam logic [28:0] LOW_MASK = 29'h1020_0801;
	localparam int SYS_DMA_POS = 0;
	localparam int SYS_MEM_POS = 2;
	localparam logic [2:0] SYS_MASK = 3'h5;
	localparam logic [2:0] SYS_RESET = 3'h4;
	localparam int SUPERVISE_POS = 0;
	// Input synchroniser depth
	localparam int SYNC_STAGES = 3;
	// Peripheral selector codes for read masking
	localparam logic [3:0] SEL_DMA = 4'h0;
	localparam logic [3:0] SEL_LAST = 4'h8;
endpackage
`default_nettype wire

// [verilog/clock_ready_irq_and_periph_gating.sv]
// Clock ready interrupt flags, peripheral resets and clock enables
//
// Functional notes
// RULE1: Write one at 23 clears fail flag 7
// RULE2: Write one at 20 clears PLL flag 4
// RULE3: Write one at 19 clears ext flag 3
// RULE4: Write one at 18 clears fast flag 2
// RULE5: Write one at 16 clears slow flag 0
// RULE6: Bits 12,11,10,8 enable ready interrupts
// RULE7: Clock failure sets flag, raises fail interrupt
// RULE8: PLL lock sets flag, cleared only by software
// RULE9: Ext ready sets flag, cleared only by software
// RULE10: Fast ready sets flag, cleared only by software
// RULE11: Slow ready sets flag, cleared only by software
// RULE12: High bus resets: serial, spi, timer, converter
// RULE13: High bus resets: ports D, C, A, altfunc
// RULE14: Low bus resets: power, twowire, watchdog, timer
// RULE15: Memory clock bit resets one, runs in sleep
// RULE16: Bit 0 gates DMA clock, resets zero
// RULE17: High bus clocks: serial, spi, timer, converter
// RULE18: High bus clocks: ports D, C, A, altfunc
// RULE19: Reads of unclocked peripheral return zero
// RULE20: Supervised ready ext clock failure sets flag
// RULE21: Ready request is OR of flag-and-enable
// RULE22: Peripheral reset held while its bit is one
`timescale 1ns/1ps
`default_nettype none
module clock_ready_irq_and_periph_gating
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic int_slow_ready_in,
	input wire logic int_fast_ready_in,
	input wire logic ext_fast_ready_in,
	input wire logic pll_lock_in,
	input wire logic ext_fast_clock_bad_in,
	input wire logic sleep_mode,
	input wire logic [31:0] periph_rdata_raw,
	input wire logic [3:0] periph_rd_sel,
	output logic [31:0] periph_rdata,
	output logic ready_irq,
	output logic clock_fail_interrupt,
	output logic [14:0] high_periph_reset,
	output logic [28:0] low_periph_reset,
	output logic [14:0] high_periph_clock_on,
	output logic dma_clock_on,
	output logic memory_clock_run
);

	////////////////////////////////////////////////////////////////////////
	// Storage

	// Register images as software sees them, reserved bits kept at zero
	logic [31:0] irq_q;
	logic [31:0] irq_d;
	logic [14:0] high_rst_q;
	logic [28:0] low_rst_q;
	logic [2:0] sys_en_q;
	logic [14:0] high_en_q;
	logic supervise_q;
	// Bus answer and output images, each a flip-flop of its own
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic ready_irq_q;
	logic [31:0] periph_rdata_q;
	logic mem_run_q;

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Writes land at the access edge, the one at which ready is given
	wire setup_phase = psel & ~penable;
	wire wr_fire = psel & penable & pwrite & pready_q;
	// Address match per register
	wire hit_irq = paddr == clk_gate_pkg::OFF_IRQ;
	wire hit_high_rst = paddr == clk_gate_pkg::OFF_HIGH_RST;
	wire hit_low_rst = paddr == clk_gate_pkg::OFF_LOW_RST;
	wire hit_sys_en = paddr == clk_gate_pkg::OFF_SYS_EN;
	wire hit_high_en = paddr == clk_gate_pkg::OFF_HIGH_EN;
	wire hit_supervise = paddr == clk_gate_pkg::OFF_SUPERVISE;
	wire hit_any = hit_irq | hit_high_rst | hit_low_rst | hit_sys_en
		| hit_high_en | hit_supervise;
	// Write strobes, one per register
	wire wr_irq = wr_fire & hit_irq;
	wire wr_high_rst = wr_fire & hit_high_rst;
	wire wr_low_rst = wr_fire & hit_low_rst;
	wire wr_sys_en = wr_fire & hit_sys_en;
	wire wr_high_en = wr_fire & hit_high_en;
	wire wr_supervise = wr_fire & hit_supervise;

	// Clear bits are write-only and read back as zero
	wire [31:0] irq_view = irq_q & ~32'hffff_0000;
	// Read data of the addressed register; unmapped reads give zero
	wire [31:0] rd_mux =
		hit_irq ? irq_view :
		hit_high_rst ? {17'h0_0000, high_rst_q} :
		hit_low_rst ? {3'h0, low_rst_q} :
		hit_sys_en ? {29'h0000_0000, sys_en_q} :
		hit_high_en ? {17'h0_0000, high_en_q} :
		hit_supervise ? {31'h0000_0000, supervise_q} :
		32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Status input synchronisers and event detection

	wire [clk_gate_pkg::NUM_SRC-1:0] src_in = {ext_fast_clock_bad_in,
		pll_lock_in, ext_fast_ready_in, int_fast_ready_in, int_slow_ready_in};
	logic [clk_gate_pkg::NUM_SRC-1:0] filt_q;
	logic [clk_gate_pkg::NUM_SRC-1:0] filt_d;
	logic [clk_gate_pkg::NUM_SRC-1:0] set_ev;
	wire [clk_gate_pkg::NUM_SRC*8-1:0] flag_pos_tab = {
		8'(clk_gate_pkg::FLAG_FAIL_POS), 8'(clk_gate_pkg::FLAG_PLL_POS),
		8'(clk_gate_pkg::FLAG_EXT_POS), 8'(clk_gate_pkg::FLAG_FAST_POS),
		8'(clk_gate_pkg::FLAG_SLOW_POS)};

	// Source index of the external fast ready level in src_in
	localparam int SRC_EXT = 2;

	// Failure only counts while supervision is on and ext clock is ready;
	// with the ext clock not ready the monitor is off, so the fail flag cannot set
	wire fail_qualified = filt_q[clk_gate_pkg::SRC_FAIL] & supervise_q
		& filt_q[SRC_EXT]; // [RULE20]

	genvar gi;
	generate
		for (gi = 0; gi < clk_gate_pkg::NUM_SRC; gi = gi + 1)
		begin : g_src
			logic [clk_gate_pkg::SYNC_STAGES-1:0] sync_q;
			// First stage feeds only the second; stages 2 and 3 vote
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					sync_q <= '0;
				else
					sync_q <= {sync_q[clk_gate_pkg::SYNC_STAGES-2:0], src_in[gi]};
			end
			// Hold the last agreed level while stages 2 and 3 still differ
			assign filt_d[gi] = (sync_q[1] == sync_q[2]) ? sync_q[2] : filt_q[gi];
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					filt_q[gi] <= 1'b0;
				else
					filt_q[gi] <= filt_d[gi];
			end
			if (gi == clk_gate_pkg::SRC_FAIL)
			begin : g_fail
				// Level set: the flag re-arms while the failure persists
				assign set_ev[gi] = fail_qualified; // [RULE7] [RULE20]
			end
			else
			begin : g_ready
				// Rising edge of the filtered ready level
				assign set_ev[gi] = filt_d[gi] & ~filt_q[gi]; // [RULE8] [RULE9] [RULE10] [RULE11]
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Interrupt flag register next value; a set beats a same-cycle clear

	always_comb
	begin
		// Clear bits never store; they act only as strobes
		irq_d = irq_q & ~32'hffff_0000;
		if (wr_irq)
			irq_d = (irq_d & ~clk_gate_pkg::IRQ_ENABLE_MASK)
				| (pwdata & clk_gate_pkg::IRQ_ENABLE_MASK); // [RULE6]
		// Clear first, then set, so a same-cycle event is never lost
		for (int i = 0; i < clk_gate_pkg::NUM_SRC; i = i + 1)
		begin
			if (wr_irq && pwdata[flag_pos_tab[i*8 +: 5] + clk_gate_pkg::CLEAR_SHIFT])
				irq_d[flag_pos_tab[i*8 +: 5]] = 1'b0; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
			if (set_ev[i])
				irq_d[flag_pos_tab[i*8 +: 5]] = 1'b1; // [RULE7] [RULE8] [RULE9] [RULE10] [RULE11]
		end
	end

	// Request is each ready flag gated by its enable, then ORed
	wire [4:0] ready_terms = irq_q[4:0]
		& irq_q[4+clk_gate_pkg::ENABLE_SHIFT:clk_gate_pkg::ENABLE_SHIFT];
	wire ready_irq_d = |ready_terms; // [RULE21] [RULE6]

	// Flags and enables of the interrupt register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 32'h0000_0000;
		else
			irq_q <= irq_d;
	end

	// One cycle late, so the request is a clean flop output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ready_irq_q <= 1'b0;
		else
			ready_irq_q <= ready_irq_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Peripheral reset and clock enable registers

	// Reset outputs follow the stored bits until software writes zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			high_rst_q <= 15'h0000;
		else if (wr_high_rst)
			high_rst_q <= pwdata[14:0] & clk_gate_pkg::HIGH_MASK; // [RULE12] [RULE13] [RULE22]
	end

	// Low bus resets hold the same way
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_rst_q <= 29'h0000_0000;
		else if (wr_low_rst)
			low_rst_q <= pwdata[28:0] & clk_gate_pkg::LOW_MASK; // [RULE14] [RULE22]
	end

	// Memory bit resets high, DMA bit low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sys_en_q <= clk_gate_pkg::SYS_RESET; // [RULE15] [RULE16]
		else if (wr_sys_en)
			sys_en_q <= pwdata[2:0] & clk_gate_pkg::SYS_MASK; // [RULE16]
	end

	// High bus clock gates; reserved bits never store
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			high_en_q <= 15'h0000;
		else if (wr_high_en)
			high_en_q <= pwdata[14:0] & clk_gate_pkg::HIGH_MASK; // [RULE17] [RULE18]
	end

	// Clock supervision switch for the failure monitor
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			supervise_q <= 1'b0;
		else if (wr_supervise)
			supervise_q <= pwdata[clk_gate_pkg::SUPERVISE_POS]; // [RULE20]
	end

	// Memory clock stops in sleep only when its bit is clear
	wire mem_run_d = ~sleep_mode | sys_en_q[clk_gate_pkg::SYS_MEM_POS]; // [RULE15]

	// Reset runs the clock, as the memory bit resets to one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mem_run_q <= 1'b1;
		else
			mem_run_q <= mem_run_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Read masking of gated peripherals; costs one cycle of latency

	wire [8:0] periph_clk_vec = {high_en_q[14], high_en_q[12], high_en_q[11],
		high_en_q[9], high_en_q[5], high_en_q[4], high_en_q[2], high_en_q[0],
		sys_en_q[clk_gate_pkg::SYS_DMA_POS]};
	wire sel_valid = periph_rd_sel <= clk_gate_pkg::SEL_LAST;
	// Unused selectors fall back to a legal index so no X leaks in
	wire [3:0] sel_idx = sel_valid ? periph_rd_sel
		: clk_gate_pkg::SEL_DMA;
	wire sel_clocked = sel_valid & periph_clk_vec[sel_idx];
	wire [31:0] periph_rdata_d = sel_clocked ? periph_rdata_raw
		: 32'h0000_0000; // [RULE19]

	// One flop on the read path keeps the output a clean register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			periph_rdata_q <= 32'h0000_0000;
		else
			periph_rdata_q <= periph_rdata_d;
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer: ready in the first access cycle, no wait states

	// Ready follows each setup cycle, so no access has to wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_q <= 1'b0;
		else
			pready_q <= setup_phase;
	end

	// Unmapped addresses answer with an error and zero data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr_q <= 1'b0;
		else
			pslverr_q <= setup_phase & ~hit_any;
	end

	// Read data taken at setup holds until the next setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (setup_phase)
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops

	// Register bus answer
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// Masked peripheral read data
	assign periph_rdata = periph_rdata_q;

	// Interrupt requests; the fail level is the flag bit itself
	assign ready_irq = ready_irq_q;
	assign clock_fail_interrupt = irq_q[clk_gate_pkg::FLAG_FAIL_POS]; // [RULE7]

	// Peripheral resets and clock gates
	assign high_periph_reset = high_rst_q;
	assign low_periph_reset = low_rst_q;
	assign high_periph_clock_on = high_en_q;
	assign dma_clock_on = sys_en_q[clk_gate_pkg::SYS_DMA_POS];
	assign memory_clock_run = mem_run_q;

endmodule
`default_nettype wire

// [dv/clk_gate_assertions.sv]
// Port-level checks for the clock gating block
`timescale 1ns/1ps
`default_nettype none
module clk_gate_assertions
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ext_fast_clock_bad_in,
	input wire logic sleep_mode,
	input wire logic [3:0] periph_rd_sel,
	input wire logic [31:0] periph_rdata,
	input wire logic clock_fail_interrupt,
	input wire logic [14:0] high_periph_reset,
	input wire logic [28:0] low_periph_reset,
	input wire logic dma_clock_on,
	input wire logic memory_clock_run
);
	// Bus decode; a write lands at the access edge
	wire logic acc = psel && penable && pready;
	wire logic hw = psel && penable && pwrite && paddr == 8'h0c;
	wire logic hit = paddr inside {8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence wr_to(logic [7:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence
	sequence calm;
		(!ext_fast_clock_bad_in) [*5];
	endsequence
	////////////////////////////////////////////////////////////
	setup_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	error_answer_a: assert property (acc |-> pslverr == !hit)
		else $error("wrong error response");
	fail_clear_a:
		assert property (calm ##0 wr_to(8'h08) ##0 pwdata[23]
			|=> !clock_fail_interrupt) else $error("fail flag kept");
	fail_set_a:
		assert property ($rose(clock_fail_interrupt)
			|-> $past(ext_fast_clock_bad_in, 2)) else $error("fail too early");
	high_rst_a:
		assert property (wr_to(8'h0c) |=> high_periph_reset
			== ($past(pwdata[14:0]) & 15'h5a35)) else $error("high reset");
	low_rst_a:
		assert property (wr_to(8'h10) |=> low_periph_reset
			== ($past(pwdata[28:0]) & 29'h1020_0801)) else $error("low reset");
	rst_hold_a:
		assert property (!hw |=> $stable(high_periph_reset))
		else $error("reset moved without write");
	dma_on_a:
		assert property (wr_to(8'h14) |=> dma_clock_on == $past(pwdata[0]))
		else $error("dma clock");
	mem_run_a:
		assert property (!$past(sleep_mode) |-> memory_clock_run)
		else $error("memory clock stopped awake");
	sel_zero_a:
		assert property (periph_rd_sel > 4'h8 |=> periph_rdata == 32'h0)
		else $error("unknown selector read");
	dma_zero_a:
		assert property (periph_rd_sel == 4'h0 && !dma_clock_on
			|=> periph_rdata == 32'h0) else $error("gated read");
endmodule
bind clock_ready_irq_and_periph_gating clk_gate_assertions chk (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.ext_fast_clock_bad_in, .sleep_mode, .periph_rd_sel, .periph_rdata,
	.clock_fail_interrupt, .high_periph_reset, .low_periph_reset,
	.dma_clock_on, .memory_clock_run);
`default_nettype wire

// [dv/periph_model.sv]
// Stand-in peripheral that feeds read data back to the gating block
`timescale 1ns/1ps
`default_nettype none
module periph_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [14:0] high_periph_reset,
	output logic [31:0] periph_rdata_raw
);
	logic [31:0] cnt_q;
	// Data moves every cycle so a stale capture cannot pass
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cnt_q <= 32'h1234_5678;
		else
			cnt_q <= cnt_q + 32'h0101_0101;
	// A peripheral held in reset reads back nothing
	assign periph_rdata_raw = (high_periph_reset != 15'h0) ? 32'h0 : cnt_q;
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the clock gating block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, prd, raw, r, v;
	logic pready, pslverr, irq, fail, dma, mem;
	logic slow = 1'b0, fast = 1'b0, ext = 1'b0, pll = 1'b0, bad = 1'b0;
	logic sleep = 1'b0, en;
	logic [3:0] sel = 4'h0;
	logic [14:0] hrst, hen;
	logic [28:0] lrst;
	logic [32:0] exp_q[$];
	logic [15:0] lf = 16'hc66b;
	int err_count = 0, n_checks = 0;
	int pos_tab[9] = '{0, 0, 2, 4, 5, 9, 11, 12, 14};
	int fpos[4] = '{0, 2, 3, 4};

	always #12.5 pclk = ~pclk;
	clock_ready_irq_and_periph_gating dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.int_slow_ready_in(slow), .int_fast_ready_in(fast),
		.ext_fast_ready_in(ext), .pll_lock_in(pll), .ext_fast_clock_bad_in(bad),
		.sleep_mode(sleep), .periph_rdata_raw(raw), .periph_rd_sel(sel),
		.periph_rdata(prd), .ready_irq(irq), .clock_fail_interrupt(fail),
		.high_periph_reset(hrst), .low_periph_reset(lrst),
		.high_periph_clock_on(hen), .dma_clock_on(dma), .memory_clock_run(mem));
	periph_model far (.pclk, .presetn, .high_periph_reset(hrst),
		.periph_rdata_raw(raw));
	////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string nm, input logic [32:0] e,
		input logic [32:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Setup, then hold until pready is seen; the idle edge avoids re-driving
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] e);
		if (!w)
			exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask
	////////////////////////////////////////////////////////////
	// Each finished read takes the oldest note
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk("read", exp_q.pop_front(), {pslverr, prdata});
	// Cut a hang short
	initial
	begin
		tick(6000);
		err_count++;
		summarize();
	end
	initial
	begin
		tick(5);
		presetn <= 1'b1;
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h4);
		rd(8'h18, 32'h0);
		// Random patterns, then gated reads of selectors 0 to 9
		repeat (3)
		begin
			lf = lfsr(lf);
			r[31:16] = lf;
			lf = lfsr(lf);
			r[15:0] = lf;
			wr(8'h0c, r);
			wr(8'h10, r);
			wr(8'h14, r);
			wr(8'h18, ~r);
			rd(8'h0c, r & 32'h5a35);
			rd(8'h10, r & 32'h1020_0801);
			rd(8'h14, r & 32'h5);
			rd(8'h18, ~r & 32'h5a35);
			chk("hrst", r & 32'h5a35, hrst);
			chk("lrst", r & 32'h1020_0801, lrst);
			chk("hen", ~r & 32'h5a35, hen);
			// Release the resets so the model returns live data
			wr(8'h0c, 32'h0);
			for (int s = 0; s < 10; s++)
			begin
				sel <= s[3:0];
				tick(2);
				v = raw;
				en = (s == 0) ? r[0] : (s < 9) ? hen[pos_tab[s]] : 1'b0;
				tick(1);
				chk("prd", en ? v : 32'h0, prd);
			end
		end
		wr(8'h0c, 32'h0);
		wr(8'h10, 32'h0);
		chk("hrst", 33'h0, hrst);
		chk("lrst", 33'h0, lrst);
		// Memory clock in sleep follows the system enable bit
		wr(8'h14, 32'h4);
		sleep <= 1'b1;
		tick(2);
		chk("mem", 1, mem);
		wr(8'h14, 32'h0);
		tick(1);
		chk("mem", 0, mem);
		sleep <= 1'b0;
		// Ready events latch flags; enables gate the request
		{slow, fast, ext, pll} <= 4'hf;
		tick(8);
		rd(8'h08, 32'h1d);
		chk("irq", 0, irq);
		wr(8'h08, 32'h1d00);
		rd(8'h08, 32'h1d1d);
		chk("irq", 1, irq);
		v = 32'h1d1d;
		foreach (fpos[i])
		begin
			v[fpos[i]] = 1'b0;
			wr(8'h08, 32'h1d00 | (32'h1 << (fpos[i] + 16)));
			rd(8'h08, v);
		end
		chk("irq", 0, irq);
		// Unsupervised failure is ignored; supervised holds until cleared
		bad <= 1'b1;
		tick(8);
		chk("fail", 33'h0, fail);
		wr(8'h20, 32'h1);
		tick(2);
		chk("fail", 33'h1, fail);
		rd(8'h08, 32'h1d80);
		bad <= 1'b0;
		tick(6);
		wr(8'h08, 32'h0080_1d00);
		chk("fail", 0, fail);
		wr(8'h1c, 32'hffff_ffff);
		apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		rd(8'h14, 32'h4);
		summarize();
	end
endmodule
`default_nettype wire
